// [common/ssp_pkg.sv]
package ssp_pkg;
  // ==========================================================
  // Register addresses on the special function register port
  localparam logic [7:0] ADR_TX_BUF   = 8'h9A;
  localparam logic [7:0] ADR_RX_BUF   = 8'h9B;
  localparam logic [7:0] ADR_MODE_CFG = 8'hE8;
  localparam logic [7:0] ADR_TGT_CFG2 = 8'hE9;
  localparam logic [7:0] ADR_STATUS   = 8'hEA;
  localparam logic [7:0] RESET_VAL    = 8'h00;
  localparam logic [7:0] IDLE_FILL    = 8'hFF;

  // ==========================================================
  // Field positions
  localparam int BYTE_BITS    = 8;
  localparam int CONT_BIT     = 7;  // continuous_stream_bit in serial_config_two
  localparam int DIR_BIT      = 0;  // transfer_direction_bit / read_write_select
  localparam int EN_BIT       = 7;  // i2c_port_on
  localparam int DIV_LSB      = 5;  // i2c_clock_divider, two bits
  localparam int CNT_MSB      = 4;  // read_length_count [4:0]
  localparam int OVW_BIT      = 2;  // overwrite_on_overflow, SPI use of serial_config_one
  localparam int SPI_RATE_LSB = 0;  // SPI half-period select, two bits
  localparam int ST_BUSY      = 7;
  localparam int ST_NOACK     = 6;
  localparam int ST_RXF       = 5;  // receive_full_flag
  localparam int ST_RXOF      = 4;  // receive_overflow_flag
  localparam int ST_TXE       = 1;  // transmit_empty_flag
  localparam int ST_TXFULL    = 0;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ       = 200;
  localparam int GAP_NS        = 50;
  localparam int GAP_CYC       = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int I2C_QTR_BASE  = 4;  // 16 core clocks per bit, four phases
  localparam int SPI_HALF_BASE = 2;

  // I2C bit phases
  localparam logic [1:0] PH_SETUP  = 2'h0;
  localparam logic [1:0] PH_RISE   = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL   = 2'h3;

  typedef enum logic [2:0] {
    SPI_IDLE  = 3'b001,
    SPI_SHIFT = 3'b010,
    SPI_GAP   = 3'b100
  } ssp_spi_st_t;

  typedef enum logic [3:0] {
    I2C_IDLE  = 4'b0001,
    I2C_START = 4'b0010,
    I2C_BYTE  = 4'b0100,
    I2C_STOP  = 4'b1000
  } ssp_i2c_st_t;

  // Divider reload for a base period scaled by a two-bit select
  function automatic logic [7:0] ssp_div_m1(input int base, input logic [1:0] sel);
    return 8'((base << sel) - 1);
  endfunction : ssp_div_m1
endpackage : ssp_pkg

// [rtl/ssp_fifo2.sv]
`timescale 1ns/100ps
module ssp_fifo2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready,
  output logic              full
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic          full_ff;
  logic          push;
  logic          pop;

  // ==========================================================
  // Handshakes
  assign in_ready  = !full_ff;
  assign out_valid = (count_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign full      = full_ff;
  assign push      = in_valid && !full_ff;
  assign pop       = out_ready && out_valid;

  function automatic logic [PW-1:0] wrap(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : wrap

  // Storage; no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and occupancy; full is a flop so the stall is glitch free
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      full_ff   <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wrap(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= wrap(rd_ptr_ff);
      end
      if (push && !pop) begin
        count_ff <= CW'(count_ff + 1'b1);
        full_ff  <= (count_ff == CW'(DEPTH - 1));
      end else if (pop && !push) begin
        count_ff <= CW'(count_ff - 1'b1);
        full_ff  <= 1'b0;
      end
    end
  end
endmodule : ssp_fifo2

// [rtl/ssp_tick_gen.sv]
`timescale 1ns/100ps
module ssp_tick_gen (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [7:0] period_m1,
  output logic            tick
);
  logic [7:0] cnt_ff;

  // ==========================================================
  // Restarts from zero whenever run drops, so each frame starts aligned
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end else if (cnt_ff >= period_m1) begin
      cnt_ff <= '0;
      tick   <= 1'b1;
    end else begin
      cnt_ff <= 8'(cnt_ff + 1'b1);
      tick   <= 1'b0;
    end
  end
endmodule : ssp_tick_gen

// [rtl/ssp_port.sv]
// Notes on behaviour
// RULE1: Continuous mode streams bytes back to back until buffer empty at byte start.
// RULE2: Continuous streaming only while continuous_stream_bit is one.
// RULE3: Transfer type from config-two bits 7 and 0: read, write, continuous.
// RULE4: Single read: buffer read starts one byte, sets receive flag, read clears.
// RULE5: Single write: buffer write sends one byte, sets transmit flag, write clears.
// RULE6: Continuous: runs until buffer and shifter empty, then deselects, flags transmit.
// RULE7: Without continuous mode a short idle gap separates bytes.
// RULE8: Transmit flag rises when the shifter loads from the transmit buffer.
// RULE9: No new transmit byte by next byte start stops transmission.
// RULE10: Each received byte placed in receive buffer sets receive flag.
// RULE11: Unread buffer on new byte sets overflow; discard or overwrite per bit.
// RULE12: I2C shares clock and data pins with SPI; port_select_bit chooses.
// RULE13: I2C is a hardware master with open-drain wired-AND lines.
// RULE14: START on idle bus, address with direction, data after ack, STOP.
// RULE15: I2C clock is core clock over 16 shifted left by divider field.
// RULE16: Target address LSB is read/write; any write starts a communication.
// RULE17: I2C works only with i2c_port_on set; address write launches.
// RULE18: Reads stop after read_length_count plus one bytes, or on error.
// RULE19: I2C registers share addresses and storage with SPI registers.
// RULE20: SPI bytes are eight bits, most significant bit first.
// RULE21: Slave select goes low before a transfer and high after it.
// RULE22: Auto acks on reads, final NACK; address rewrite gives repeated START.
// RULE23: Read bit one fills receive buffer; zero sends transmit buffer data.
// RULE24: Idle I2C master releases both lines.
// RULE25: After reset all registers zero, interfaces idle.
`timescale 1ns/100ps
module ssp_port #(
  parameter int TX_DEPTH = 2
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       port_select_bit,
  input  wire logic       miso_pin,
  input  wire logic       dat_pin_in,
  output logic            clk_pin_out,
  output logic            clk_pin_oe,
  output logic            dat_pin_out,
  output logic            dat_pin_oe,
  output logic            slave_sel_n,
  output logic            tx_buffer_full
);
  import ssp_pkg::*;

  // ==========================================================
  // Declarations
  logic [7:0]  mode_cfg_ff;   // serial_config_one / i2c_mode_config
  logic [7:0]  cfg2_ff;       // serial_config_two / i2c_target_address
  logic [7:0]  rx_buf_ff;
  logic        rx_full_ff;
  logic        rx_ovf_ff;
  logic        tx_empty_ff;
  logic        noack_ff;
  logic        miso_m_ff, miso_s_ff, sda_m_ff, sda_s_ff;
  logic        wr_tx, rd_rx, wr_st, adr_wr;
  logic        tx_in_ready, tx_out_valid, tx_pop;
  logic [7:0]  tx_out_data;
  logic        rx_evt;
  logic [7:0]  rx_byte;

  ssp_spi_st_t spi_st_ff;
  logic [7:0]  spi_sh_ff, spi_rxsh_ff, gap_ff;
  logic [2:0]  spi_bit_ff;
  logic        spi_hi_ff, spi_cap_ff, rd_req_ff;
  logic        spi_on, spi_cont, spi_dir, spi_tick;
  logic        spi_byte_end, spi_load, spi_rd_start, spi_cont_end, spi_rx_evt;

  ssp_i2c_st_t i2c_st_ff;
  logic [1:0]  ph_ff;
  logic [3:0]  ibit_ff;
  logic [7:0]  ish_ff, ircv_ff;
  logic [4:0]  icnt_ff;
  logic        scl_low_ff, sda_low_ff, is_adr_ff, ird_ff, ack_ff, restart_ff;
  logic        i2c_on, i2c_tick, i2c_rxb, i2c_last, i2c_done, i2c_pop, i2c_rx_evt;

  // ==========================================================
  // Register port decode
  assign wr_tx  = sfr_wr && (sfr_addr == ADR_TX_BUF);
  assign rd_rx  = sfr_rd && (sfr_addr == ADR_RX_BUF);
  assign wr_st  = sfr_wr && (sfr_addr == ADR_STATUS);
  assign adr_wr = sfr_wr && (sfr_addr == ADR_TGT_CFG2);

  // Pin inputs pass two flops before use
  always_ff @(posedge clk) begin
    if (reset) begin
      miso_m_ff <= 1'b0;
      miso_s_ff <= 1'b0;
      sda_m_ff  <= 1'b1;
      sda_s_ff  <= 1'b1;
    end else begin
      miso_m_ff <= miso_pin;
      miso_s_ff <= miso_m_ff;
      sda_m_ff  <= dat_pin_in;
      sda_s_ff  <= sda_m_ff;
    end
  end

  // ==========================================================
  // Transmit buffer; a write while full is dropped, full is visible
  assign tx_pop = spi_load || i2c_pop;

  ssp_fifo2 #(.W(BYTE_BITS), .DEPTH(TX_DEPTH)) u_tx_buf (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (wr_tx && tx_in_ready),
    .in_data   (sfr_wdata),
    .in_ready  (tx_in_ready),
    .out_valid (tx_out_valid),
    .out_data  (tx_out_data),
    .out_ready (tx_pop),
    .full      (tx_buffer_full)
  );

  // ==========================================================
  // Configuration storage, one copy for both interfaces
  // RULE19: shared register storage
  // RULE25: zero after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_cfg_ff <= RESET_VAL;
      cfg2_ff     <= RESET_VAL;
    end else begin
      if (sfr_wr && (sfr_addr == ADR_MODE_CFG)) begin
        mode_cfg_ff <= sfr_wdata;
      end
      if (adr_wr) begin
        cfg2_ff <= sfr_wdata;
      end
    end
  end

  // ==========================================================
  // SPI master
  // RULE12: SPI only when not selecting I2C
  assign spi_on   = !port_select_bit;
  // RULE2: continuous gated by its bit
  assign spi_cont = cfg2_ff[CONT_BIT];
  // RULE3: transfer type decode
  assign spi_dir  = cfg2_ff[DIR_BIT];

  ssp_tick_gen u_spi_tick (
    .clk       (clk),
    .reset     (reset),
    .run       (spi_st_ff == SPI_SHIFT),
    .period_m1 (ssp_div_m1(SPI_HALF_BASE, mode_cfg_ff[SPI_RATE_LSB+:2])),
    .tick      (spi_tick)
  );

  assign spi_byte_end = (spi_st_ff == SPI_SHIFT) && spi_tick && spi_hi_ff
                        && (spi_bit_ff == 3'(BYTE_BITS - 1));
  // RULE5: buffer write starts a byte
  // RULE1: back to back only if a byte waits
  // RULE9: empty buffer at byte start stops
  assign spi_load     = spi_on && spi_dir && tx_out_valid
                        && ((spi_st_ff == SPI_IDLE) || (spi_byte_end && spi_cont));
  // RULE4: read start after buffer read
  assign spi_rd_start = spi_on && (spi_st_ff == SPI_IDLE) && !spi_dir && !spi_cont && rd_req_ff;
  assign spi_cont_end = spi_byte_end && spi_cont && !spi_load;
  assign spi_rx_evt   = spi_byte_end && spi_cap_ff;

  // Pending single-byte read, armed by a read of the receive buffer
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_req_ff <= 1'b0;
    end else begin
      if (spi_rd_start || !spi_on) begin
        rd_req_ff <= 1'b0;
      end
      if (rd_rx && spi_on && !spi_dir && !spi_cont) begin
        rd_req_ff <= 1'b1;
      end
    end
  end

  // Shift engine, clock idles low, sample on rise and shift on fall
  always_ff @(posedge clk) begin
    if (reset || !spi_on) begin
      spi_st_ff   <= SPI_IDLE;
      spi_sh_ff   <= RESET_VAL;
      spi_rxsh_ff <= RESET_VAL;
      spi_bit_ff  <= '0;
      spi_hi_ff   <= 1'b0;
      spi_cap_ff  <= 1'b0;
      gap_ff      <= '0;
    end else begin
      unique case (spi_st_ff)
        SPI_IDLE: begin
          if (spi_load) begin
            spi_sh_ff  <= tx_out_data;
            spi_cap_ff <= spi_cont;
            spi_bit_ff <= '0;
            spi_st_ff  <= SPI_SHIFT;
          end else if (spi_rd_start) begin
            spi_sh_ff  <= IDLE_FILL;
            spi_cap_ff <= 1'b1;
            spi_bit_ff <= '0;
            spi_st_ff  <= SPI_SHIFT;
          end
        end
        SPI_SHIFT: begin
          if (spi_tick && !spi_hi_ff) begin
            spi_hi_ff   <= 1'b1;
            // RULE20: MSB first capture
            spi_rxsh_ff <= {spi_rxsh_ff[6:0], miso_s_ff};
          end else if (spi_tick) begin
            spi_hi_ff <= 1'b0;
            if (spi_bit_ff != 3'(BYTE_BITS - 1)) begin
              spi_bit_ff <= 3'(spi_bit_ff + 1'b1);
              spi_sh_ff  <= {spi_sh_ff[6:0], 1'b0};
            end else if (spi_load) begin
              spi_sh_ff  <= tx_out_data;
              spi_bit_ff <= '0;
            end else begin
              // RULE7: gap unless streaming
              spi_st_ff <= spi_cont ? SPI_IDLE : SPI_GAP;
              gap_ff    <= '0;
            end
          end
        end
        SPI_GAP: begin
          gap_ff <= 8'(gap_ff + 1'b1);
          if (gap_ff == 8'(GAP_CYC - 1)) begin
            spi_st_ff <= SPI_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // I2C master
  // RULE17: enable gates the port
  assign i2c_on     = port_select_bit && mode_cfg_ff[EN_BIT];
  assign i2c_rxb    = ird_ff && !is_adr_ff;
  assign i2c_last   = (icnt_ff == mode_cfg_ff[CNT_MSB:0]);
  assign i2c_done   = i2c_tick && (i2c_st_ff == I2C_BYTE) && (ph_ff == PH_FALL)
                      && (ibit_ff == 4'(BYTE_BITS));
  // RULE23: write data comes from transmit buffer
  assign i2c_pop    = i2c_done && !ird_ff && !ack_ff && tx_out_valid;
  assign i2c_rx_evt = i2c_done && i2c_rxb;

  // RULE15: quarter-bit ticks give core/(16<<div)
  ssp_tick_gen u_i2c_tick (
    .clk       (clk),
    .reset     (reset),
    .run       (i2c_st_ff != I2C_IDLE),
    .period_m1 (ssp_div_m1(I2C_QTR_BASE, mode_cfg_ff[DIV_LSB+:2])),
    .tick      (i2c_tick)
  );

  // RULE22: address write while busy asks for repeated START
  always_ff @(posedge clk) begin
    if (reset || !i2c_on) begin
      restart_ff <= 1'b0;
    end else begin
      if (i2c_st_ff == I2C_START) begin
        restart_ff <= 1'b0;
      end
      if (adr_wr && (i2c_st_ff != I2C_IDLE)) begin
        restart_ff <= 1'b1;
      end
    end
  end

  // Bit sequencer, four phases per bit; lines are pull-low requests
  // RULE14: START, address, ack, data, STOP
  always_ff @(posedge clk) begin
    if (reset || !i2c_on) begin
      i2c_st_ff  <= I2C_IDLE;
      ph_ff      <= PH_SETUP;
      ibit_ff    <= '0;
      ish_ff     <= RESET_VAL;
      ircv_ff    <= RESET_VAL;
      icnt_ff    <= '0;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      is_adr_ff  <= 1'b0;
      ird_ff     <= 1'b0;
      ack_ff     <= 1'b0;
    end else if (i2c_st_ff == I2C_IDLE) begin
      // RULE16: address write launches
      if (adr_wr || restart_ff) begin
        i2c_st_ff <= I2C_START;
        ph_ff     <= PH_SETUP;
      end
    end else if (i2c_tick) begin
      ph_ff <= 2'(ph_ff + 1'b1);
      unique case (i2c_st_ff)
        I2C_START: begin
          unique case (ph_ff)
            PH_SETUP:  sda_low_ff <= 1'b0;
            PH_RISE:   scl_low_ff <= 1'b0;
            PH_SAMPLE: sda_low_ff <= 1'b1;
            PH_FALL: begin
              scl_low_ff <= 1'b1;
              i2c_st_ff  <= I2C_BYTE;
              ibit_ff    <= '0;
              ish_ff     <= cfg2_ff;
              is_adr_ff  <= 1'b1;
              ird_ff     <= cfg2_ff[DIR_BIT];
              icnt_ff    <= '0;
            end
          endcase
        end
        I2C_BYTE: begin
          unique case (ph_ff)
            PH_SETUP: begin
              // RULE22: ack each read byte, NACK the last
              if (ibit_ff == 4'(BYTE_BITS)) begin
                sda_low_ff <= i2c_rxb && !i2c_last;
              end else begin
                sda_low_ff <= !i2c_rxb && !ish_ff[7];
              end
            end
            PH_RISE: scl_low_ff <= 1'b0;
            PH_SAMPLE: begin
              if (ibit_ff == 4'(BYTE_BITS)) begin
                ack_ff <= sda_s_ff;
              end else begin
                ircv_ff <= {ircv_ff[6:0], sda_s_ff};
              end
            end
            PH_FALL: begin
              scl_low_ff <= 1'b1;
              if (ibit_ff != 4'(BYTE_BITS)) begin
                ish_ff  <= {ish_ff[6:0], 1'b0};
                ibit_ff <= 4'(ibit_ff + 1'b1);
              end else begin
                ibit_ff <= '0;
                if (!i2c_rxb && ack_ff) begin
                  i2c_st_ff <= I2C_STOP;
                end else if (i2c_rxb && !i2c_last) begin
                  // RULE18: count bytes read
                  icnt_ff <= 5'(icnt_ff + 1'b1);
                end else if (!i2c_rxb && ird_ff) begin
                  is_adr_ff <= 1'b0;
                end else if (!i2c_rxb && tx_out_valid) begin
                  ish_ff    <= tx_out_data;
                  is_adr_ff <= 1'b0;
                end else begin
                  i2c_st_ff <= restart_ff ? I2C_START : I2C_STOP;
                end
              end
            end
          endcase
        end
        I2C_STOP: begin
          unique case (ph_ff)
            PH_SETUP:  sda_low_ff <= 1'b1;
            PH_RISE:   scl_low_ff <= 1'b0;
            PH_SAMPLE: sda_low_ff <= 1'b0;
            PH_FALL:   i2c_st_ff  <= I2C_IDLE;
          endcase
        end
        I2C_IDLE: ;
      endcase
    end
  end

  // ==========================================================
  // Receive buffer and flags, shared by both interfaces
  assign rx_evt  = spi_rx_evt || i2c_rx_evt;
  assign rx_byte = port_select_bit ? ircv_ff : spi_rxsh_ff;

  // Clears first so a same-cycle set wins
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_buf_ff  <= RESET_VAL;
      rx_full_ff <= 1'b0;
      rx_ovf_ff  <= 1'b0;
    end else begin
      if (rd_rx || (wr_st && !sfr_wdata[ST_RXF])) begin
        rx_full_ff <= 1'b0;
      end
      if (wr_st && !sfr_wdata[ST_RXOF]) begin
        rx_ovf_ff <= 1'b0;
      end
      if (rx_evt && rx_full_ff && !rd_rx) begin
        // RULE11: overflow, keep or overwrite
        rx_ovf_ff <= 1'b1;
        if (!port_select_bit && mode_cfg_ff[OVW_BIT]) begin
          rx_buf_ff <= rx_byte;
        end
      end else if (rx_evt) begin
        // RULE10: new byte flags receive
        rx_buf_ff  <= rx_byte;
        rx_full_ff <= 1'b1;
      end
    end
  end

  // Transmit-empty and no-ack flags
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_empty_ff <= 1'b0;
      noack_ff    <= 1'b0;
    end else begin
      if (wr_tx || (wr_st && !sfr_wdata[ST_TXE])) begin
        tx_empty_ff <= 1'b0;
      end
      if (wr_st && !sfr_wdata[ST_NOACK]) begin
        noack_ff <= 1'b0;
      end
      // RULE8: flag on shifter load
      // RULE6: flag again at stream end
      if (tx_pop || spi_cont_end) begin
        tx_empty_ff <= 1'b1;
      end
      if (i2c_done && !i2c_rxb && ack_ff) begin
        noack_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_rdata <= RESET_VAL;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        ADR_RX_BUF:   sfr_rdata <= rx_buf_ff;
        ADR_MODE_CFG: sfr_rdata <= mode_cfg_ff;
        ADR_TGT_CFG2: sfr_rdata <= cfg2_ff;
        ADR_STATUS: begin
          sfr_rdata            <= RESET_VAL;
          sfr_rdata[ST_BUSY]   <= (i2c_st_ff != I2C_IDLE);
          sfr_rdata[ST_NOACK]  <= noack_ff;
          sfr_rdata[ST_RXF]    <= rx_full_ff;
          sfr_rdata[ST_RXOF]   <= rx_ovf_ff;
          sfr_rdata[ST_TXE]    <= tx_empty_ff;
          sfr_rdata[ST_TXFULL] <= tx_buffer_full;
        end
        default:      sfr_rdata <= RESET_VAL;
      endcase
    end
  end

  // ==========================================================
  // Shared pins, all outputs from flops
  always_ff @(posedge clk) begin
    if (reset) begin
      clk_pin_out <= 1'b0;
      clk_pin_oe  <= 1'b0;
      dat_pin_out <= 1'b0;
      dat_pin_oe  <= 1'b0;
      slave_sel_n <= 1'b1;
    end else if (port_select_bit) begin
      // RULE13: open drain, only ever pull low
      // RULE24: released when idle
      clk_pin_out <= 1'b0;
      clk_pin_oe  <= scl_low_ff;
      dat_pin_out <= 1'b0;
      dat_pin_oe  <= sda_low_ff;
      slave_sel_n <= 1'b1;
    end else begin
      // RULE12: SPI drives the shared pins
      clk_pin_out <= spi_hi_ff;
      clk_pin_oe  <= 1'b1;
      // RULE20: MSB out first
      dat_pin_out <= spi_sh_ff[7];
      dat_pin_oe  <= 1'b1;
      // RULE21: select low during shift
      slave_sel_n <= (spi_st_ff != SPI_SHIFT);
    end
  end
endmodule : ssp_port

// [test/ssp_port_props.sv]
`timescale 1ns/100ps
// ==========================================
// Pin and register port checker
module ssp_port_props (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       port_select_bit,
  input wire logic       clk_pin_out,
  input wire logic       clk_pin_oe,
  input wire logic       dat_pin_out,
  input wire logic       dat_pin_oe,
  input wire logic       slave_sel_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [4:0] rise_ff;
  logic       clk_q_ff;
  // Count clock rises per select window; wraps, only the low bits matter
  always_ff @(posedge clk) begin
    clk_q_ff <= clk_pin_out;
    if (reset || slave_sel_n) rise_ff <= 5'h00;
    else if (clk_pin_out && !clk_q_ff) rise_ff <= rise_ff + 5'h01;
  end
  a_spi_pins_driven: assert property (!port_select_bit && !$past(port_select_bit) |-> clk_pin_oe && dat_pin_oe)
    else $error("spi pins not driven");
  a_i2c_pull_only: assert property (port_select_bit && $past(port_select_bit) |-> !clk_pin_out && !dat_pin_out)
    else $error("i2c line driven high");
  a_i2c_no_select: assert property (port_select_bit && $past(port_select_bit) |-> slave_sel_n)
    else $error("select low in i2c mode");
  a_sclk_when_selected: assert property (!port_select_bit && $rose(clk_pin_out) |-> !slave_sel_n)
    else $error("clock pulse without select");
  a_whole_bytes: assert property (!port_select_bit && $rose(slave_sel_n) |-> rise_ff[2:0] == 3'h0)
    else $error("frame not whole bytes");
  a_tx_reads_zero: assert property (sfr_rd && sfr_addr == 8'h9A |=> sfr_rdata == 8'h00)
    else $error("tx buffer readable");
  a_rdata_holds: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
    else $error("read data moved");
  a_reset_clears: assert property (disable iff (1'b0) reset |=> slave_sel_n && sfr_rdata == 8'h00)
    else $error("reset state wrong");
  c_spi_frame: cover property ($rose(slave_sel_n));
  c_i2c_pull: cover property (port_select_bit && $rose(dat_pin_oe));
  c_rx_read: cover property (sfr_rd && sfr_addr == 8'h9B);
endmodule : ssp_port_props
bind ssp_port ssp_port_props u_props (.clk, .reset, .sfr_addr, .sfr_rd, .sfr_rdata, .port_select_bit,
  .clk_pin_out, .clk_pin_oe, .dat_pin_out, .dat_pin_oe, .slave_sel_n);

// [test/ssp_spi_slave.sv]
`timescale 1ns/100ps
// ==========================================
// Mode 0 slave on the shared pins
module ssp_spi_slave (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh = 8'h00;
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  always @(negedge ss_n) begin
    sh = tx_byte;
    miso = tx_byte[7];
  end
  always @(negedge sclk) if (!ss_n) begin
    sh = {sh[6:0], sh[7]};
    miso = sh[7];
  end
  always @(posedge sclk) if (!ss_n) rx_byte = {rx_byte[6:0], mosi};
  // Released line flips so a stale bit is never read as data
  always @(posedge ss_n) miso = ~miso;
endmodule : ssp_spi_slave

// [test/tb_top.sv]
`timescale 1ns/100ps
// ==========================================
// Register-level bench
module tb_top;
  import ssp_pkg::*;
  logic       clk = 1'b0, reset = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, port_select_bit = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rx_byte;
  logic       miso_pin, clk_pin_out, clk_pin_oe, dat_pin_out, dat_pin_oe, slave_sel_n, tx_buffer_full;
  int         failures = 0, n_checks = 0, rises = 0;
  logic [7:0] adrs [6] = '{ADR_TX_BUF, ADR_RX_BUF, ADR_MODE_CFG, ADR_TGT_CFG2, ADR_STATUS, 8'h00};
  // Pulled-up wire; no slave answers so every ack reads high
  wire        dat_pin_in = dat_pin_oe ? dat_pin_out : 1'b1;
  always #2.5 clk = ~clk;
  always @(posedge slave_sel_n) rises++;
  ssp_port dut (.clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .port_select_bit,
    .miso_pin, .dat_pin_in, .clk_pin_out, .clk_pin_oe, .dat_pin_out, .dat_pin_oe, .slave_sel_n, .tx_buffer_full);
  ssp_spi_slave u_slave (.sclk(clk_pin_out), .mosi(dat_pin_out), .ss_n(slave_sel_n), .tx_byte(8'h3C),
    .miso(miso_pin), .rx_byte(rx_byte));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, v, 1'b1};
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(negedge clk);
    {sfr_addr, sfr_rd} = {a, 1'b1};
    @(negedge clk);
    sfr_rd = 1'b0;
    chk(sfr_rdata & m, e);
  endtask : rd
  // Quiet pins for 40 cycles means the transfer is over
  task automatic idle();
    int q = 0;
    repeat (4000) begin
      @(negedge clk);
      q = (port_select_bit ? !(clk_pin_oe | dat_pin_oe) : slave_sel_n) ? q + 1 : 0;
      if (q == 40) return;
    end
    failures++;
  endtask : idle
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    foreach (adrs[i]) rd(adrs[i], 8'h00);
    // Pins go to SPI only now, so the reset read of 0x9B arms no read
    port_select_bit = 1'b0;
    $display("test reset done");
    wr(ADR_MODE_CFG, 8'h03);
    wr(ADR_TGT_CFG2, 8'h01);
    wr(ADR_TX_BUF, 8'hA5);
    idle();
    chk(rx_byte, 8'hA5);
    rd(ADR_STATUS, 8'h02);
    for (int m = 0; m < 2; m++) begin
      wr(ADR_TGT_CFG2, m ? 8'h81 : 8'h01);
      rises = 0;
      wr(ADR_TX_BUF, 8'h11);
      wr(ADR_TX_BUF, 8'h22);
      idle();
      chk(8'(rises), m ? 8'h01 : 8'h02);
      chk(rx_byte, 8'h22);
    end
    rd(ADR_STATUS, 8'h32);
    rd(ADR_RX_BUF, 8'h3C);
    $display("test spi write done");
    wr(ADR_STATUS, 8'h00);
    wr(ADR_TGT_CFG2, 8'h00);
    rd(ADR_RX_BUF, 8'h3C);
    idle();
    chk(rx_byte, IDLE_FILL);
    rd(ADR_STATUS, 8'h20, 8'hF0);
    rd(ADR_RX_BUF, 8'h3C);
    rd(ADR_STATUS, 8'h00, 8'h20);
    idle();
    $display("test spi read done");
    @(negedge clk);
    port_select_bit = 1'b1;
    repeat (2) @(negedge clk);
    chk({6'h00, clk_pin_oe, dat_pin_oe}, 8'h00);
    repeat (2) wr(ADR_TX_BUF, 8'h5A);
    chk({7'h00, tx_buffer_full}, 8'h01);
    wr(ADR_MODE_CFG, 8'h80);
    wr(ADR_TGT_CFG2, 8'hA0);
    rd(ADR_STATUS, 8'h80, 8'h80);
    repeat (200) if (!dat_pin_oe) @(negedge clk);
    chk({7'h00, clk_pin_oe}, 8'h00);
    idle();
    rd(ADR_STATUS, 8'h40, 8'hC0);
    $display("test i2c done");
    finish_test();
  end
  // Whole run is about 2000 cycles; allow ten times that
  initial begin
    #100000;
    failures++;
    finish_test();
  end
endmodule : tb_top
